// File: adc_seq_consts.vh
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// host byte offsets
`define OFS_CONTROL 10'h080
`define OFS_SW_TRIGGER 10'h082
`define OFS_SAMPLE_PTR 10'h084
`define OFS_SEQ_PTR 10'h085
`define OFS_SAMPLE_PTR_LO 10'h086
`define OFS_GAIN_FIRST 10'h101
`define OFS_GAIN_LAST 10'h13f
`define OFS_SEQ_FIRST 10'h201
`define OFS_SEQ_LAST 10'h3ff

// control register bit positions
`define CTL_SEQ_IRQ_PEND 13
`define CTL_SEQ_IRQ_EN 12
`define CTL_SEQ_ENABLE 8
`define CTL_ACQ_ACTIVE 7
`define CTL_IMAGE_MODE 6
`define CTL_RANDOM_MODE 5
`define CTL_SOFT_RESET 4
`define CTL_IRQ_EN 3

// sequence entry fields
`define ENT_END_OF_SEQ 7
`define ENT_STOP 6
`define ENT_IRQ 5
`define ENT_CHAN_MSB 4

// input configurations
`define CFG_SINGLE_ENDED 2'h0
`define CFG_PSEUDO_DIFF 2'h1
`define CFG_DIFFERENTIAL 2'h2

// reset values
`define RST_CONTROL 16'h0000
`define RST_SAMPLE_PTR 15'h0000
`define RST_SEQ_PTR 8'h00

`endif

// File: two_entry_buffer.v
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter WIDTH = 17
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] slot [0:1];
  reg wrIdx_ff;
  reg rdIdx_ff;
  reg [1:0] count_ff;
  wire push;
  wire pop;

  assign inReady = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData = slot[rdIdx_ff];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge clk) begin
    if (push) begin
      slot[wrIdx_ff] <= inData;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrIdx_ff <= 1'b0;
      rdIdx_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wrIdx_ff <= ~wrIdx_ff;
      end
      if (pop) begin
        rdIdx_ff <= ~rdIdx_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: sample_store.v
`timescale 1ns/1ps
`default_nettype none
module sample_store #(
  parameter ADDR_W = 15,
  parameter DATA_W = 16
) (
  // clock
  input wire clk,
  // write port
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [DATA_W-1:0] wrData,
  // read port
  input wire rdEn,
  input wire [ADDR_W-1:0] rdAddr,
  output reg [DATA_W-1:0] rdData
);
  reg [DATA_W-1:0] words [0:(1<<ADDR_W)-1];

  // one word per conversion result
  always @(posedge clk) begin
    if (wrEn) begin
      words[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= words[rdAddr];
    end
  end
endmodule
`default_nettype wire

// File: adc_sequence_pointer_control.v
// Notes on behaviour
// - a 32K by 16 sample store holds results, host can read it
// - sample pointer moves once per conversion, after its result is written
// - hidden start value reloads the sample pointer at end of sequence in image mode
// - sample pointer readable as a byte or as a word
// - pointer shows next word to write; pointer and store always readable
// - sequence store: 256 bytes on odd addresses from 201h, eight bits
// - entry: channel in bits 4..0, three flags above
// - end flag reloads sequence pointer, and sample pointer in image mode
// - stop flag halts sequential activity until a trigger
// - entry interrupt flag sets pending if bits 3 and 12; clear writes 13
// - five channel bits single ended or pseudo, four bits differential
// - channel bits are a plain binary channel number 0 to 31
// - 8-bit sequence pointer at 85h, 00h is 201h, ffh is 3ffh
// - sequential conversions start on software, clock or external trigger
// - random mode: write to gain or sequence store converts that channel
// - control bit 5 low is sequential mode, the reset default
// - sequential mode converts one to 256 entries in entry order
// - bit 8 low resets the sequence controller, no acquisition then
// - contiguous mode always increments, never reloads the sample pointer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_sequence_pointer_control #(
  parameter PTR_W = 15,
  parameter DATA_W = 16
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // host register port
  input wire hostWrite,
  input wire hostRead,
  input wire hostByte,
  input wire [9:0] hostAddr,
  input wire [15:0] hostWrData,
  output reg [15:0] hostRdData_ff,
  output reg hostRdValid_ff,
  // host sample store read
  input wire storeRead,
  input wire [PTR_W-1:0] storeAddr,
  output wire [DATA_W-1:0] storeData,
  // triggers and strap
  input wire extTrigger,
  input wire trigClock,
  input wire [1:0] inputConfig,
  // converter
  output reg convStart_ff,
  output reg [4:0] convChannel_ff,
  input wire convDone,
  input wire [DATA_W-1:0] convData,
  // status
  output reg seqIrqPending_ff,
  output reg acqActive_ff
);
  localparam ST_IDLE = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_POST = 3'h4;

  reg [7:0] seqMem [0:255];
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [15:0] ctl_ff;
  reg [PTR_W-1:0] samplePtr_ff;
  reg [PTR_W-1:0] samplePtrInit_ff;
  reg [7:0] seqPtr_ff;
  reg [7:0] seqPtrInit_ff;
  reg [7:0] entry_ff;
  reg [7:0] nxt_entry;
  reg random_ff;
  reg softRst_ff;
  reg [15:0] nxt_rdData;

  wire loLane;
  wire hiLane;
  wire wrCtl;
  wire wrTrig;
  wire wrPtrWord;
  wire wrPtrHi;
  wire wrPtrLo;
  wire wrSeqPtr;
  wire wrSeqMem;
  wire wrGain;
  wire [7:0] wrIndex;
  wire [7:0] wrByte;
  wire ctlReset;
  wire anyTrigger;
  wire bufInReady;
  wire bufOutValid;
  wire bufOutReady;
  wire [DATA_W:0] bufOutData;
  wire bufPush;
  wire storeWrite;
  wire reloadSample;
  wire irqHit;
  wire irqClear;
  wire [4:0] chanSel;

  // byte lanes: even byte on the high half, odd byte on the low half
  assign loLane = !hostByte || hostAddr[0];
  assign hiLane = !hostByte || !hostAddr[0];
  assign wrByte = hostAddr[0] ? hostWrData[7:0] : hostWrData[15:8];

  // register decode
  assign wrCtl = hostWrite && ({hostAddr[9:1], 1'b0} == `OFS_CONTROL);
  assign wrTrig = hostWrite && ({hostAddr[9:1], 1'b0} == `OFS_SW_TRIGGER);
  assign wrPtrWord = hostWrite && !hostByte &&
    (hostAddr == `OFS_SAMPLE_PTR);
  assign wrPtrHi = hostWrite && hostByte && (hostAddr == `OFS_SAMPLE_PTR);
  assign wrPtrLo = hostWrite && hostByte &&
    (hostAddr == `OFS_SAMPLE_PTR_LO + 10'h001);
  assign wrSeqPtr = hostWrite && hostByte && (hostAddr == `OFS_SEQ_PTR);
  assign wrSeqMem = hostWrite && hostAddr[0] &&
    (hostAddr >= `OFS_SEQ_FIRST) && (hostAddr <= `OFS_SEQ_LAST);
  assign wrGain = hostWrite && hostAddr[0] &&
    (hostAddr >= `OFS_GAIN_FIRST) && (hostAddr <= `OFS_GAIN_LAST);
  assign wrIndex = hostAddr[8:1];

  // controller reset by bit 8 low or the falling edge of bit 4
  assign ctlReset = !ctl_ff[`CTL_SEQ_ENABLE] ||
    (softRst_ff && !ctl_ff[`CTL_SOFT_RESET]);
  assign anyTrigger = wrTrig || extTrigger || trigClock;

  // result path: buffer, then the store when the host is not reading it
  assign bufPush = (state_ff == ST_WAIT) && convDone;
  assign bufOutReady = !storeRead;
  assign storeWrite = bufOutValid && bufOutReady;
  assign reloadSample = bufOutData[DATA_W] &&
    ctl_ff[`CTL_IMAGE_MODE];

  // sequence interrupt
  assign irqHit = (state_ff == ST_POST) && entry_ff[`ENT_IRQ] &&
    ctl_ff[`CTL_IRQ_EN] && ctl_ff[`CTL_SEQ_IRQ_EN];
  assign irqClear = wrCtl && hiLane && hostWrData[`CTL_SEQ_IRQ_PEND];

  // channel select by input configuration
  assign chanSel = (inputConfig == `CFG_DIFFERENTIAL) ?
    {1'b0, entry_ff[3:0]} : entry_ff[`ENT_CHAN_MSB:0];

  two_entry_buffer #(
    .WIDTH(DATA_W + 1)
  ) resultBuffer (
    .clk(clk),
    .rstn(rstn),
    .inValid(bufPush),
    .inReady(bufInReady),
    .inData({entry_ff[`ENT_END_OF_SEQ] && !random_ff, convData}),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  sample_store #(
    .ADDR_W(PTR_W),
    .DATA_W(DATA_W)
  ) results (
    .clk(clk),
    .wrEn(storeWrite),
    .wrAddr(samplePtr_ff),
    .wrData(bufOutData[DATA_W-1:0]),
    .rdEn(storeRead),
    .rdAddr(storeAddr),
    .rdData(storeData)
  );

  // sequence store writes
  always @(posedge clk) begin
    if (wrSeqMem) begin
      seqMem[wrIndex] <= wrByte;
    end
  end

  // sequencer next state
  always @* begin
    nxt_state = state_ff;
    nxt_entry = entry_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ctl_ff[`CTL_RANDOM_MODE]) begin
          if (wrSeqMem) begin
            nxt_entry = wrByte;
            nxt_state = ST_START;
          end else if (wrGain) begin
            nxt_entry = {3'h0, wrIndex[4:0]};
            nxt_state = ST_START;
          end
        end else if (anyTrigger) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        nxt_entry = seqMem[seqPtr_ff];
        nxt_state = ST_START;
      end
      ST_START: begin
        if (bufInReady) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (convDone) begin
          nxt_state = ST_POST;
        end
      end
      ST_POST: begin
        if (random_ff || entry_ff[`ENT_STOP]) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_state = ST_FETCH;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (ctlReset) begin
      nxt_state = ST_IDLE;
    end
  end

  // sequencer registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      entry_ff <= 8'h00;
      random_ff <= 1'b0;
      convStart_ff <= 1'b0;
      convChannel_ff <= 5'h00;
      acqActive_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      entry_ff <= nxt_entry;
      if (state_ff == ST_IDLE) begin
        random_ff <= ctl_ff[`CTL_RANDOM_MODE];
      end
      convStart_ff <= (state_ff == ST_START) && bufInReady && !ctlReset;
      if (state_ff == ST_START) begin
        convChannel_ff <= chanSel;
      end
      acqActive_ff <= (nxt_state != ST_IDLE);
    end
  end

  // control register and sequence pointer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= `RST_CONTROL;
      softRst_ff <= 1'b0;
      seqIrqPending_ff <= 1'b0;
      seqPtr_ff <= `RST_SEQ_PTR;
      seqPtrInit_ff <= `RST_SEQ_PTR;
    end else begin
      softRst_ff <= ctl_ff[`CTL_SOFT_RESET];
      if (wrCtl && hiLane) begin
        ctl_ff[15:8] <= hostWrData[15:8] & 8'h11;
      end
      if (wrCtl && loLane) begin
        ctl_ff[7:0] <= hostWrData[7:0] & 8'h78;
      end
      if (irqHit) begin
        seqIrqPending_ff <= 1'b1;
      end else if (irqClear || ctlReset) begin
        seqIrqPending_ff <= 1'b0;
      end
      if (wrSeqPtr) begin
        seqPtr_ff <= hostWrData[7:0];
        seqPtrInit_ff <= hostWrData[7:0];
      end else if (ctlReset) begin
        seqPtr_ff <= seqPtrInit_ff;
      end else if ((state_ff == ST_POST) && !random_ff) begin
        if (entry_ff[`ENT_END_OF_SEQ]) begin
          seqPtr_ff <= seqPtrInit_ff;
        end else begin
          seqPtr_ff <= seqPtr_ff + 8'h01;
        end
      end
    end
  end

  // sample pointer with hidden start value
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      samplePtr_ff <= `RST_SAMPLE_PTR;
      samplePtrInit_ff <= `RST_SAMPLE_PTR;
    end else begin
      if (wrPtrWord) begin
        samplePtr_ff <= hostWrData[PTR_W-1:0];
        samplePtrInit_ff <= hostWrData[PTR_W-1:0];
      end else if (wrPtrHi) begin
        samplePtr_ff[PTR_W-1:8] <= wrByte[PTR_W-9:0];
        samplePtrInit_ff[PTR_W-1:8] <= wrByte[PTR_W-9:0];
      end else if (wrPtrLo) begin
        samplePtr_ff[7:0] <= wrByte;
        samplePtrInit_ff[7:0] <= wrByte;
      end else if (storeWrite) begin
        if (reloadSample) begin
          samplePtr_ff <= samplePtrInit_ff;
        end else begin
          samplePtr_ff <= samplePtr_ff + 1'b1;
        end
      end
    end
  end

  // read data
  always @* begin
    nxt_rdData = 16'h0000;
    if ({hostAddr[9:1], 1'b0} == `OFS_CONTROL) begin
      nxt_rdData = ctl_ff;
      nxt_rdData[`CTL_SEQ_IRQ_PEND] = seqIrqPending_ff;
      nxt_rdData[`CTL_ACQ_ACTIVE] = acqActive_ff;
    end else if (!hostByte && hostAddr == `OFS_SAMPLE_PTR) begin
      nxt_rdData = {{(16-PTR_W){1'b0}}, samplePtr_ff};
    end else if (hostAddr == `OFS_SAMPLE_PTR) begin
      nxt_rdData[15:8] = {1'b0, samplePtr_ff[PTR_W-1:8]};
    end else if (hostAddr == `OFS_SEQ_PTR) begin
      nxt_rdData[7:0] = seqPtr_ff;
    end else if ({hostAddr[9:1], 1'b0} == `OFS_SAMPLE_PTR_LO) begin
      nxt_rdData[7:0] = samplePtr_ff[7:0];
    end
    if (hostByte) begin
      nxt_rdData = hostAddr[0] ? {8'h00, nxt_rdData[7:0]} :
        {nxt_rdData[15:8], 8'h00};
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hostRdData_ff <= 16'h0000;
      hostRdValid_ff <= 1'b0;
    end else begin
      hostRdValid_ff <= hostRead;
      if (hostRead) begin
        hostRdData_ff <= nxt_rdData;
      end
    end
  end
endmodule
`default_nettype wire

// File: adc_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host port
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic hostByte,
  input wire logic [9:0] hostAddr,
  input wire logic [15:0] hostWrData,
  input wire logic [15:0] hostRdData_ff,
  input wire logic hostRdValid_ff,
  // triggers and converter
  input wire logic extTrigger,
  input wire logic [1:0] inputConfig,
  input wire logic convStart_ff,
  input wire logic [4:0] convChannel_ff,
  // status
  input wire logic seqIrqPending_ff,
  input wire logic acqActive_ff
);
  reg ctlEn_ff, ctlEnOld_ff, ctlRand_ff, ctlIrq_ff;
  wire ctlWr = hostWrite && !hostByte && hostAddr == 10'h080;
  // shadow of the control bits
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctlEn_ff <= 1'b0;
      ctlEnOld_ff <= 1'b0;
      ctlRand_ff <= 1'b0;
      ctlIrq_ff <= 1'b0;
    end else begin
      ctlEnOld_ff <= ctlEn_ff;
      if (ctlWr) begin
        ctlEn_ff <= hostWrData[8];
        ctlRand_ff <= hostWrData[5];
        ctlIrq_ff <= hostWrData[3] && hostWrData[12];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_randWr;
    hostWrite && hostByte && hostAddr[9] && hostAddr[0] && ctlRand_ff
      && ctlEn_ff && !acqActive_ff;
  endsequence
  sequence s_trig;
    $rose(extTrigger) && ctlEn_ff && !ctlRand_ff && !acqActive_ff;
  endsequence
  property p_randStart;
    s_randWr |-> ##2 convStart_ff
      && convChannel_ff[3:0] == $past(hostWrData[3:0], 2);
  endproperty
  a_randStart: assert property (p_randStart)
    else $error("random write gave no start");
  property p_trigStart;
    s_trig |-> ##[2:4] convStart_ff;
  endproperty
  a_trigStart: assert property (p_trigStart)
    else $error("trigger gave no start");
  property p_startPulse;
    convStart_ff |=> !convStart_ff [*3];
  endproperty
  a_startPulse: assert property (p_startPulse)
    else $error("start pulse too long");
  property p_diffChan;
    convStart_ff && inputConfig == 2'h2 |-> !convChannel_ff[4];
  endproperty
  a_diffChan: assert property (p_diffChan)
    else $error("differential channel above 15");
  property p_disabled;
    !ctlEn_ff && !ctlEnOld_ff |-> !convStart_ff;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("start while disabled");
  property p_irqEn;
    $rose(seqIrqPending_ff) |-> ctlIrq_ff;
  endproperty
  a_irqEn: assert property (p_irqEn)
    else $error("pending without enables");
  property p_rdValid;
    hostRead |=> hostRdValid_ff;
  endproperty
  a_rdValid: assert property (p_rdValid)
    else $error("read not answered");
  property p_seqPtrByte;
    hostRead && hostByte && hostAddr == 10'h085 |=>
      hostRdData_ff[15:8] == 8'h00;
  endproperty
  a_seqPtrByte: assert property (p_seqPtrByte)
    else $error("sequence pointer wider than a byte");
endmodule
bind adc_sequence_pointer_control adc_seq_properties adc_seq_properties_i (
  .clk(clk), .rstn(rstn), .hostWrite(hostWrite), .hostRead(hostRead),
  .hostByte(hostByte), .hostAddr(hostAddr), .hostWrData(hostWrData),
  .hostRdData_ff(hostRdData_ff), .hostRdValid_ff(hostRdValid_ff),
  .extTrigger(extTrigger), .inputConfig(inputConfig),
  .convStart_ff(convStart_ff), .convChannel_ff(convChannel_ff),
  .seqIrqPending_ff(seqIrqPending_ff), .acqActive_ff(acqActive_ff));
`default_nettype wire

// File: conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_model (
  // clock
  input wire logic clk,
  // converter side
  input wire logic convStart,
  input wire logic [4:0] convChannel,
  input wire logic [3:0] lag,
  output var logic convDone,
  output var logic [15:0] convData
);
  initial begin
    convDone = 1'b0;
    convData = 16'h0000;
    forever begin
      @(posedge clk);
      if (convStart) begin
        repeat (lag) @(posedge clk);
        convDone <= 1'b1;
        convData <= {convChannel, 11'h2a5};
        @(posedge clk);
        convDone <= 1'b0;
        convData <= ~{convChannel, 11'h2a5};
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rstn, hostWrite, hostRead, hostByte, storeRead, stPend;
  logic extTrigger, trigClock, convStart, convDone, hostRdValid, seqIrq, acq;
  logic [9:0] hostAddr;
  logic [15:0] hostWrData, hostRdData, storeData, convData;
  logic [14:0] storeAddr, p;
  logic [1:0] inputConfig;
  logic [4:0] convChannel, ch;
  logic [3:0] lag;
  logic [15:0] expQ[$], stQ[$];
  int n_fail, total_checks, seed, k;
  adc_sequence_pointer_control adc_sequence_pointer_control_i (
    .clk(clk), .rstn(rstn), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostByte(hostByte), .hostAddr(hostAddr), .hostWrData(hostWrData),
    .hostRdData_ff(hostRdData), .hostRdValid_ff(hostRdValid),
    .storeRead(storeRead), .storeAddr(storeAddr), .storeData(storeData),
    .extTrigger(extTrigger), .trigClock(trigClock),
    .inputConfig(inputConfig), .convStart_ff(convStart),
    .convChannel_ff(convChannel), .convDone(convDone), .convData(convData),
    .seqIrqPending_ff(seqIrq), .acqActive_ff(acq));
  conv_model conv_model_i (.clk(clk), .convStart(convStart),
    .convChannel(convChannel), .lag(lag), .convDone(convDone),
    .convData(convData));
  task automatic cmp(input [15:0] e, input [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic acc(input w, input b, input [9:0] a, input [15:0] d);
    @(posedge clk);
    hostWrite <= w;
    hostRead <= !w;
    hostByte <= b;
    hostAddr <= a;
    hostWrData <= d;
    @(posedge clk);
    hostWrite <= 1'b0;
    hostRead <= 1'b0;
  endtask
  task automatic rd(input b, input [9:0] a, input [15:0] e);
    expQ.push_back(e);
    acc(1'b0, b, a, 16'h0000);
  endtask
  task automatic rdStore(input [14:0] a, input [15:0] e);
    stQ.push_back(e);
    @(posedge clk);
    storeRead <= 1'b1;
    storeAddr <= a;
    @(posedge clk);
    storeRead <= 1'b0;
  endtask
  task automatic waitIdle;
    int i;
    repeat (6) @(posedge clk);
    for (i = 0; i < 400 && acq !== 1'b0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse(input logic x);
    @(posedge clk);
    if (x) extTrigger <= 1'b1;
    else trigClock <= 1'b1;
    @(posedge clk);
    extTrigger <= 1'b0;
    trigClock <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // result monitor
  always @(posedge clk) begin
    stPend <= storeRead && stQ.size() > 0;
    if (hostRdValid === 1'b1) cmp(expQ.pop_front(), hostRdData);
    if (stPend) cmp(stQ.pop_front(), storeData);
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    {rstn, hostWrite, hostRead, hostByte, storeRead} = 5'h00;
    {extTrigger, trigClock, hostAddr, hostWrData, storeAddr} = 43'h0;
    inputConfig = 2'h0;
    lag = 4'h0;
    seed = 6891;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(1'b0, 10'h080, 16'h0000);
    rd(1'b1, 10'h085, 16'h0000);
    p = 15'($random(seed));
    acc(1'b1, 1'b0, 10'h084, {1'b0, p});
    rd(1'b0, 10'h084, {1'b0, p});
    rd(1'b1, 10'h084, {1'b0, p[14:8], 8'h00});
    rd(1'b1, 10'h087, {8'h00, p[7:0]});
    acc(1'b1, 1'b0, 10'h080, 16'h1128);
    for (k = 0; k < 6; k++) begin
      inputConfig <= 2'(k % 3);
      lag <= 4'($random(seed));
      ch = 5'($random(seed));
      acc(1'b1, 1'b1, {1'b1, 3'h0, ch, 1'b1}, {8'h00, 3'h1, ch});
      waitIdle;
      rdStore(p, {ch[4] && inputConfig != 2'h2, ch[3:0], 11'h2a5});
      p = p + 15'd1;
      rd(1'b0, 10'h084, {1'b0, p});
      rd(1'b0, 10'h080, 16'h3128);
      acc(1'b1, 1'b0, 10'h080, 16'h3128);
      rd(1'b0, 10'h080, 16'h1128);
    end
    // sequential run in image mode
    acc(1'b1, 1'b0, 10'h080, 16'h0000);
    for (k = 0; k < 3; k++) begin
      acc(1'b1, 1'b1, 10'h201 + 10'(2 * k),
          {8'h00, k == 2 ? 3'h6 : 3'h0, 5'(3 * k + 7)});
    end
    acc(1'b1, 1'b1, 10'h085, 16'h0000);
    acc(1'b1, 1'b0, 10'h084, {1'b0, p});
    acc(1'b1, 1'b0, 10'h080, 16'h0140);
    acc(1'b1, 1'b1, 10'h082, 16'h0000);
    waitIdle;
    rd(1'b0, 10'h084, {1'b0, p});
    rd(1'b1, 10'h085, 16'h0000);
    for (k = 0; k < 3; k++)
      rdStore(p + 15'(k), {5'(3 * k + 7), 11'h2a5});
    // restart by trigger while the store drain stalls
    lag <= 4'h0;
    @(posedge clk);
    storeRead <= 1'b1;
    pulse(1'b1);
    repeat (40) @(posedge clk);
    storeRead <= 1'b0;
    waitIdle;
    rd(1'b0, 10'h084, {1'b0, p});
    acc(1'b1, 1'b0, 10'h080, 16'h0100);
    pulse(1'b0);
    waitIdle;
    rd(1'b0, 10'h084, {1'b0, p + 15'd3});
    rdStore(p + 15'd2, {5'd13, 11'h2a5});
    acc(1'b1, 1'b0, 10'h080, 16'h0000);
    pulse(1'b1);
    waitIdle;
    rd(1'b0, 10'h084, {1'b0, p + 15'd3});
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule
`default_nettype wire
